//--- shared/pll_clock_defs.svh
// Offsets, field positions, reset values and timing counts for the clock mode generator.
`ifndef PLL_CLOCK_DEFS_SVH
`define PLL_CLOCK_DEFS_SVH

`define CMC_ADDR          16'h0058
`define CMC_MUL_HI        15
`define CMC_MUL_LO        12
`define CMC_HALF_BIT      11
`define CMC_CNT_HI        10
`define CMC_CNT_LO        3
`define CMC_ON_BIT        2
`define CMC_NDIV_BIT      1
`define CMC_STAT_BIT      0
`define CMC_MUL_DIV4      4'hf
`define CMC_RST_DIV2      16'h0000
`define CMC_RST_X10       16'h9007
`define CMC_RST_X5        16'h4007
`define CMC_RST_X2        16'h1007
`define CMC_RST_X1        16'hf007
`define CMC_RST_DIV4      16'hf000
`define CMC_RST_BYPASS    16'h0000
`define LOCK_SCALE        16

`endif

//--- shared/pll_clock_pkg.sv
// Types shared by the clock mode generator and its bench.
package pll_clock_pkg;

    typedef struct packed {
        logic [3:0] mul;
        logic       half;
        logic [7:0] lock_count;
        logic       pll_on;
        logic       pll_select;
        logic       status;
    } clock_mode_s;

    typedef enum logic [2:0] {
        ST_DIV     = 3'b001,
        ST_ACQUIRE = 3'b010,
        ST_LOCKED  = 3'b100
    } pll_state_e;

    typedef struct packed {
        logic [3:0] mul;
        logic       half;
        logic       enable;
        logic       locked;
        logic       select_pll;
    } pll_ctrl_s;

endpackage

//--- core/pll_clock_mode_generator.sv
// Clock mode generator: strap-loaded mode register, divider path and PLL lock sequencing.
// Register layout, top bit first:
//   [15:12] Multiplier field; the PLL ratio is this field plus one.
//   [11]    Halving bit; when set, the ratio above is halved.
//   [10:3]  Lock count, in units of LOCK_SCALE reference cycles.
//   [2]     PLL power bit; it keeps the PLL running while the divider clocks the device.
//   [1]     PLL select bit; writing one starts a switch into PLL mode.
//   [0]     Status bit, read only; it reads one while the PLL clocks the device.
//   A multiplier field of all ones selects divide by four in divider mode, else divide by two.
//
// Reset behaviour:
//   The strap pins pass two flip-flops, so reset must stay low for at least three edges
//   with the straps steady before the mode register holds the strap value.
//   Straps that select a PLL mode leave reset already locked, because the PLL has had all
//   of reset to settle; a software switch into PLL mode always waits out the lock timer.
//
// Limitations:
//   The lock timer is a fixed count, not a measurement of the loop, so software that
//   programs too small a count gets the PLL clock before the loop has settled.
//   The timer is 12 bits wide; lock count times LOCK_SCALE must stay below 4096.
//
`timescale 1ns/1ps
`include "pll_clock_defs.svh"

module pll_clock_mode_generator #(
    parameter int LOCK_SCALE = `LOCK_SCALE
) (
    // Reference clock and device reset.
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // Clock mode strap pins.
    input  wire logic        clock_strap_pin_a_in,
    input  wire logic        clock_strap_pin_b_in,
    input  wire logic        clock_strap_pin_c_in,
    // Internal data bus access to the mode register.
    input  wire logic [15:0] data_addr_in,
    input  wire logic        data_wr_in,
    input  wire logic        data_rd_in,
    input  wire logic [15:0] data_wdata_in,
    output logic      [15:0] data_rdata_out,
    output logic             data_rvalid_out,
    // Clock generation controls and status.
    output logic             div_clk_out,
    output pll_clock_pkg::pll_ctrl_s pll_ctrl_out
);

    // Strap synchronisers; left out of reset because they must sample during it.
    logic [2:0] strap_meta_reg;
    logic [2:0] strap_sync_reg;

    // First stage: the straps are asynchronous levels and may go metastable here.
    always_ff @(posedge clk_in) begin
        strap_meta_reg <= {clock_strap_pin_a_in, clock_strap_pin_b_in, clock_strap_pin_c_in};
    end

    // Second stage: only this stage feeds the decode below.
    always_ff @(posedge clk_in) begin
        strap_sync_reg <= strap_meta_reg;
    end

    function automatic logic [15:0] strap_value(input logic [2:0] straps);
        logic [15:0] value;
        value = `CMC_RST_DIV2;
        unique case (straps)
            3'b001: value = `CMC_RST_X10;
            3'b010: value = `CMC_RST_X5;
            3'b100: value = `CMC_RST_X2;
            3'b110: value = `CMC_RST_X1;
            3'b101: value = `CMC_RST_DIV4;
            3'b011: value = `CMC_RST_BYPASS;
            3'b000: value = `CMC_RST_DIV2;
            3'b111: value = `CMC_RST_DIV2;
        endcase
        return value;
    endfunction

    // Lock wait in reference cycles, cut to the width of the timer.
    function automatic logic [11:0] lock_span_of(input logic [7:0] count);
        logic [31:0] span;
        span = 32'(count) * 32'(LOCK_SCALE);
        return span[11:0];
    endfunction

    // Mode register, sequencer state and their next values.
    pll_clock_pkg::clock_mode_s mode_reg;
    pll_clock_pkg::clock_mode_s mode_next;
    pll_clock_pkg::pll_state_e  state_reg;
    pll_clock_pkg::pll_state_e  state_next;
    // Lock timer, divider and read port.
    logic [11:0] lock_cnt_reg;
    logic [11:0] lock_cnt_next;
    logic [1:0]  div_cnt_reg;
    logic        div_clk_reg;
    logic [15:0] rdata_reg;
    logic        rvalid_reg;
    pll_clock_pkg::pll_ctrl_s ctrl_reg;

    // Bus decode.
    wire logic        hit      = (data_addr_in == `CMC_ADDR);
    wire logic        wr_hit   = data_wr_in && hit;
    wire logic        rd_hit   = data_rd_in && hit;
    wire pll_clock_pkg::clock_mode_s wr_mode = data_wdata_in;
    wire logic [15:0] strap_mode = strap_value(strap_sync_reg);
    wire pll_clock_pkg::clock_mode_s reset_mode = strap_mode;

    // The lock wait is the programmed count in units of LOCK_SCALE reference cycles.
    wire logic [11:0] lock_span = lock_span_of(wr_mode.lock_count);
    wire logic        pll_runs  = mode_next.pll_on || mode_next.pll_select;
    wire logic        ratio_chg = wr_hit &&
                                  ({wr_mode.mul, wr_mode.half} != {mode_reg.mul, mode_reg.half});
    wire logic        timer_done = (lock_cnt_reg <= 12'h0001);

    // Writes that steer the lock sequencer.
    wire logic        enter_pll  = wr_hit && wr_mode.pll_select;
    wire logic        leave_pll  = wr_hit && !wr_mode.pll_select;

    // Mode register: the status bit is not writable and follows the clock source.
    always_comb begin
        mode_next = mode_reg;
        if (wr_hit) begin
            mode_next = wr_mode;
        end
        mode_next.status = (state_next == pll_clock_pkg::ST_LOCKED);
    end

    // Lock sequencing: the state decides which clock the device runs from.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            pll_clock_pkg::ST_DIV: begin
                if (enter_pll) begin
                    state_next = pll_clock_pkg::ST_ACQUIRE;
                end
            end
            pll_clock_pkg::ST_ACQUIRE: begin
                if (leave_pll) begin
                    state_next = pll_clock_pkg::ST_DIV;
                end else if (!ratio_chg && timer_done) begin
                    state_next = pll_clock_pkg::ST_LOCKED;
                end
            end
            pll_clock_pkg::ST_LOCKED: begin
                if (leave_pll) begin
                    state_next = pll_clock_pkg::ST_DIV;
                end else if (ratio_chg) begin
                    // A new ratio must be reacquired; the divider carries the device meanwhile.
                    state_next = pll_clock_pkg::ST_ACQUIRE;
                end
            end
        endcase
    end

    // Lock timer: reloaded on every entry into acquisition and on every ratio change during
    // it, so a new ratio never inherits a partly spent wait.
    always_comb begin
        lock_cnt_next = lock_cnt_reg;
        unique case (state_reg)
            pll_clock_pkg::ST_DIV: begin
                if (enter_pll) begin
                    lock_cnt_next = lock_span;
                end
            end
            pll_clock_pkg::ST_ACQUIRE: begin
                if (leave_pll) begin
                    lock_cnt_next = lock_cnt_reg;
                end else if (ratio_chg) begin
                    lock_cnt_next = lock_span;
                end else if (timer_done) begin
                    lock_cnt_next = 12'h000;
                end else begin
                    lock_cnt_next = lock_cnt_reg - 12'h001;
                end
            end
            pll_clock_pkg::ST_LOCKED: begin
                if (!leave_pll && ratio_chg) begin
                    lock_cnt_next = lock_span;
                end
            end
        endcase
    end

    // Reset keeps reloading the strap value, so the last edge of reset decides the mode.
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            mode_reg <= reset_mode;
        end else begin
            mode_reg <= mode_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            lock_cnt_reg <= 12'h000;
        end else begin
            lock_cnt_reg <= lock_cnt_next;
        end
    end

    // Straps that start in PLL mode count as locked: the PLL had all of reset to settle.
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_reg <= reset_mode.pll_select ? pll_clock_pkg::ST_LOCKED
                                               : pll_clock_pkg::ST_DIV;
        end else begin
            state_reg <= state_next;
        end
    end

    // Divider path runs at all times so the device clock never stops. The ratio comes from
    // the register, not from a write in flight, so the divider changes step one cycle after
    // the control outputs show the new multiplier field.
    wire logic div4      = (mode_reg.mul == `CMC_MUL_DIV4);
    wire logic [1:0] div_cnt_next = div_cnt_reg + 2'b01;
    wire logic div_clk_next = div4 ? div_cnt_next[1] : div_cnt_next[0];

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            div_cnt_reg <= 2'b00;
        end else begin
            div_cnt_reg <= div_cnt_next;
        end
    end

    // The divided clock is a flip-flop output, so it carries no decode glitches.
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            div_clk_reg <= 1'b0;
        end else begin
            div_clk_reg <= div_clk_next;
        end
    end

    // Lock and selection move together, so the device never runs from an unlocked PLL;
    // both come from the next state so they line up with the status bit.
    wire logic next_locked = (state_next == pll_clock_pkg::ST_LOCKED);
    wire logic next_select = (state_next == pll_clock_pkg::ST_LOCKED);

    // PLL controls: the ratio is mul+1, halved when the half bit is set (32 settings).
    wire pll_clock_pkg::pll_ctrl_s ctrl_next = '{
        mul:        mode_next.mul,
        half:       mode_next.half,
        enable:     pll_runs,
        locked:     next_locked,
        select_pll: next_select
    };

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ctrl_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Reads answer one cycle later; other addresses read as zero. A read in the cycle of a
    // write to the register returns the old value.
    wire logic [15:0] rdata_next = rd_hit ? 16'(mode_reg) : 16'h0000;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Every read is answered, mapped or not, so a bus master never waits on a missing reply.
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= data_rd_in;
        end
    end

    // All outputs come straight from flip-flops.

    assign data_rdata_out  = rdata_reg;
    assign data_rvalid_out = rvalid_reg;
    assign div_clk_out     = div_clk_reg;
    assign pll_ctrl_out    = ctrl_reg;

endmodule

//--- dv/pll_clock_chk.sv
// Port-level assertions for the clock mode generator.
`timescale 1ns/1ps
`include "pll_clock_defs.svh"
module pll_clock_chk #(
    parameter int LOCK_SCALE = 1
) (
    // Clock, reset and straps.
    input wire logic                     clk_in,
    input wire logic                     reset_n_in,
    input wire logic                     clock_strap_pin_a_in,
    input wire logic                     clock_strap_pin_b_in,
    input wire logic                     clock_strap_pin_c_in,
    // Register access and clock controls.
    input wire logic [15:0]              data_addr_in,
    input wire logic                     data_wr_in,
    input wire logic                     data_rd_in,
    input wire logic [15:0]              data_wdata_in,
    input wire logic [15:0]              data_rdata_out,
    input wire logic                     data_rvalid_out,
    input wire logic                     div_clk_out,
    input wire pll_clock_pkg::pll_ctrl_s pll_ctrl_out
);
    // The window allows one cycle of slack because the lock edge is registered.
    localparam int LOCK_LO = 2 * LOCK_SCALE;
    localparam int LOCK_HI = 2 * LOCK_SCALE + 1;
    wire logic [2:0] strap = {clock_strap_pin_a_in, clock_strap_pin_b_in, clock_strap_pin_c_in};
    wire logic       hit = data_addr_in == `CMC_ADDR;
    wire logic       st_pll = strap inside {3'b001, 3'b010, 3'b100, 3'b110};
    wire logic [3:0] st_mul = strap == 3'b001 ? 4'h9 : strap == 3'b010 ? 4'h4 :
                              strap == 3'b100 ? 4'h1 :
                              strap[2] & (strap[1] ^ strap[0]) ? 4'hf : 4'h0;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // Only a lock count of two is timed here, and only when the PLL is not yet locked.
    sequence pll_req;
        data_wr_in && hit && data_wdata_in[1] && data_wdata_in[10:3] == 8'h02 && !pll_ctrl_out.locked;
    endsequence
    sequence lock_seen;
        ##[LOCK_LO:LOCK_HI] pll_ctrl_out.locked;
    endsequence
    strap_mode_a: assert property ($rose(reset_n_in) |=>
        pll_ctrl_out.mul == st_mul && pll_ctrl_out.locked == st_pll) else $error("strap mode wrong");
    rd_answer_a: assert property (data_rd_in |=> data_rvalid_out)
        else $error("read not answered");
    rd_pulse_a: assert property (!data_rd_in |=> !data_rvalid_out)
        else $error("stray read valid");
    rd_unmapped_a: assert property (data_rd_in && !hit |=> data_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    wr_ignore_a: assert property (data_wr_in && !hit |=> $stable(pll_ctrl_out.mul))
        else $error("unmapped write took effect");
    mul_load_a: assert property (data_wr_in && hit |=>
        pll_ctrl_out.mul == $past(data_wdata_in[15:12])) else $error("ratio not loaded");
    lock_early_a: assert property (pll_req |=> !pll_ctrl_out.locked)
        else $error("switched before lock timer");
    lock_time_a: assert property (pll_req |-> lock_seen)
        else $error("lock not reached in time");
    en_load_a: assert property (data_wr_in && hit |=> pll_ctrl_out.enable ==
        ($past(data_wdata_in[2]) || $past(data_wdata_in[1]))) else $error("PLL enable not loaded");
    half_load_a: assert property (data_wr_in && hit |=>
        pll_ctrl_out.half == $past(data_wdata_in[11])) else $error("halving bit not loaded");
    sel_lock_a: assert property (pll_ctrl_out.locked == pll_ctrl_out.select_pll)
        else $error("select and lock disagree");
    drop_div_a: assert property (data_wr_in && hit && !data_wdata_in[1] |=>
        !pll_ctrl_out.locked) else $error("divider mode not entered");
    div_two_a: assert property ((pll_ctrl_out.mul != 4'hf)[*3] |=> $changed(div_clk_out))
        else $error("divide by two broken");
    div_four_a: assert property ((pll_ctrl_out.mul == 4'hf)[*4] ##0 $changed(div_clk_out)
        |=> $stable(div_clk_out)) else $error("divide by four broken");
endmodule

//--- dv/test_pll_clock_mode_generator.sv
// Self-checking bench for the clock mode generator.
`timescale 1ns/1ps
module test_pll_clock_mode_generator;
    logic                     clk_in = 1'b0;
    logic                     reset_n_in = 1'b0;
    logic                     clock_strap_pin_a_in = 1'b0;
    logic                     clock_strap_pin_b_in = 1'b0;
    logic                     clock_strap_pin_c_in = 1'b0;
    logic [15:0]              data_addr_in = 16'h0000;
    logic                     data_wr_in = 1'b0;
    logic                     data_rd_in = 1'b0;
    logic [15:0]              data_wdata_in = 16'h0000;
    logic [15:0]              data_rdata_out;
    logic                     data_rvalid_out;
    logic                     div_clk_out;
    pll_clock_pkg::pll_ctrl_s pll_ctrl_out;
    logic [15:0]              exp_q[$];
    logic [15:0]              rst_val[8] = '{16'h0000, 16'h9007, 16'h4007, 16'h0000,
                                             16'h1007, 16'hf000, 16'hf007, 16'h0000};
    logic [31:0]              lfsr = 32'h0000_eca2;
    int                       errors = 0;
    int                       num_checks = 0;
    // A lock scale of one keeps lock waits to a few cycles.
    pll_clock_mode_generator #(.LOCK_SCALE(1)) pll_clock_mode_generator_inst (.*);
    initial forever #2 clk_in = ~clk_in;
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic compare16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Straps change together with reset so the sync flops settle before release.
    task automatic boot(input logic [2:0] s);
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        {clock_strap_pin_a_in, clock_strap_pin_b_in, clock_strap_pin_c_in} <= s;
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
    endtask
    task automatic cyc(input logic wr, input logic rd, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        data_wr_in <= wr;
        data_rd_in <= rd;
        data_addr_in <= a;
        data_wdata_in <= d;
        @(posedge clk_in);
        data_wr_in <= 1'b0;
        data_rd_in <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        cyc(1'b0, 1'b1, a, 16'h0000);
    endtask
    always @(negedge clk_in) begin
        if (data_rvalid_out === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("Error at %0t: got %h expected no read", $time, data_rdata_out);
            end else compare16(data_rdata_out, exp_q.pop_front());
        end
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        errors++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            if (i != 3) begin
                boot(i[2:0]);
                rd(16'h0058, rst_val[i]);
            end
        end
        rd(16'h0059, 16'h0000);
        cyc(1'b1, 1'b0, 16'h005a, 16'hffff);
        rd(16'h0058, 16'h0000);
        cyc(1'b1, 1'b0, 16'h0058, 16'h3016);
        for (int k = 0; k < 20 && pll_ctrl_out.locked !== 1'b1; k++) @(negedge clk_in);
        rd(16'h0058, 16'h3017);
        cyc(1'b1, 1'b0, 16'h0058, 16'h3014);
        rd(16'h0058, 16'h3014);
        repeat (6) begin
            lfsr = lfsr_next(lfsr);
            cyc(1'b1, 1'b0, 16'h0058, lfsr[15:0] & 16'hfffc);
            rd(16'h0058, lfsr[15:0] & 16'hfffc);
        end
        repeat (3) @(posedge clk_in);
        print_verdict();
    end
endmodule
bind pll_clock_mode_generator pll_clock_chk #(.LOCK_SCALE(LOCK_SCALE)) pll_clock_chk_inst (.*);
